// ---- fwp_pkg.sv ----
// fwp_pkg: opcodes, field positions, reset values and sizes for the flash write-protect block.
// assumes: used by the top only, which passes the block sizes on to the lock memory.
`default_nettype none
package fwp_pkg;
  localparam logic [7:0] OP_WRITE_LOCK_REG = 8'h2F;
  localparam logic [7:0] OP_MODE_SELECT = 8'h68;
  localparam logic [7:0] OP_SINGLE_LOCK = 8'h36;
  localparam logic [7:0] OP_SINGLE_UNLOCK = 8'h39;
  localparam logic [7:0] OP_READ_LOCK = 8'h3C;
  localparam logic [7:0] OP_GANG_LOCK = 8'h7E;
  localparam logic [7:0] OP_GANG_UNLOCK = 8'h98;
  localparam logic [7:0] OP_CLEAR_FAIL = 8'h30;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_READ_LOCK_REG = 8'h2B;
  localparam int BIT_MODE_SEL = 7;
  localparam int BIT_ERASE_FAIL = 6;
  localparam int BIT_PROG_FAIL = 5;
  localparam int BIT_CONT_PROG = 4;
  localparam int BIT_OTP_LOCK = 1;
  localparam int BIT_FACTORY_LOCK = 0;
  localparam logic [7:0] LOCK_REG_RESET = 8'h00;
  localparam int ADDR_BYTES = 3;
  localparam int BLOCK_COUNT = 256;
  localparam int BLOCK_AW = 8;
  localparam int BP_WIDTH = 4;
  localparam logic [7:0] BITCNT_BYTE_DONE = 8'h07;
endpackage
`default_nettype wire

// ---- fwp_spi_shift.sv ----
// fwp_spi_shift: samples the serial link with the system clock and assembles bytes.
// assumes: serial clock far slower than clk_in; all link pins asynchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module fwp_spi_shift (
  input wire logic clk_in,          // system clock
  input wire logic resetn_in,       // async reset, active low
  input wire logic cs_n_in,         // raw chip select
  input wire logic sclk_in,         // raw serial clock
  input wire logic si_in,           // raw serial input
  output logic sel_out,             // chip select held low (synced)
  output logic cs_rise_out,         // pulse: frame ended
  output logic sclk_fall_out,       // pulse: serial clock falling edge
  output logic byte_out,            // pulse: byte complete
  output logic aligned_out,         // no partial byte in flight
  output logic [7:0] data_out       // completed byte
);
  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] ck_s;
    logic [1:0] si_s;
    logic cs_prev;
    logic ck_prev;
    logic [2:0] bitc;
    logic [7:0] sh;
    logic byte_p;
    logic rise_p;
    logic fall_p;
  } fwp_shift_st_t;
  fwp_shift_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.cs_s = {st_q.cs_s[0], cs_n_in};
    st_d.ck_s = {st_q.ck_s[0], sclk_in};
    st_d.si_s = {st_q.si_s[0], si_in};
    st_d.cs_prev = st_q.cs_s[1];
    st_d.ck_prev = st_q.ck_s[1];
    st_d.byte_p = 1'b0;
    st_d.rise_p = st_q.cs_s[1] & ~st_q.cs_prev;
    st_d.fall_p = 1'b0;
    // count kept through the end pulse so a cut byte is still visible
    if (st_q.cs_prev) begin
      st_d.bitc = 3'h0;
    end else if (st_q.ck_s[1] & ~st_q.ck_prev) begin
      st_d.sh = {st_q.sh[6:0], st_q.si_s[1]};
      st_d.bitc = st_q.bitc + 3'h1;
      st_d.byte_p = (st_q.bitc == 3'h7);
    end else if (~st_q.ck_s[1] & st_q.ck_prev) begin
      st_d.fall_p = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= '{cs_s: 2'h3, cs_prev: 1'b1, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign sel_out = ~st_q.cs_prev;
  assign cs_rise_out = st_q.rise_p;
  assign sclk_fall_out = st_q.fall_p;
  assign byte_out = st_q.byte_p;
  assign aligned_out = (st_q.bitc == 3'h0);
  assign data_out = st_q.sh;
endmodule
`default_nettype wire

// ---- fwp_lock_mem.sv ----
// fwp_lock_mem: volatile per-block lock bits with registered read port.
// assumes: one write or gang fill per cycle; gang fill wins over a single write.
`timescale 1ns/1ps
`default_nettype none
module fwp_lock_mem #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk_in,          // system clock
  input wire logic resetn_in,       // async reset, active low
  input wire logic fill_in,         // pulse: load every bit with fill_val_in
  input wire logic fill_val_in,     // value for fill
  input wire logic wr_in,           // pulse: write one bit
  input wire logic [AW-1:0] addr_in, // bit index
  input wire logic wr_val_in,       // value to write
  output logic rd_out               // registered lock bit at addr_in
);
  logic [DEPTH-1:0] bits_q;
  logic rd_q;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_bit
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          bits_q[g] <= 1'b1;
        end else if (fill_in) begin
          bits_q[g] <= fill_val_in;
        end else if (wr_in && addr_in == AW'(g)) begin
          bits_q[g] <= wr_val_in;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_q <= 1'b1;
    end else begin
      rd_q <= bits_q[addr_in];
    end
  end
  assign rd_out = rd_q;
endmodule
`default_nettype wire

// ---- fwp_top.sv ----
// fwp_top: write-protect mode select, lock/fail status register and block lock commands.
// assumes: host spi controller on the pins; array engine reports attempts and failures.
// Notes on behaviour
// - eight-bit lock/fail register: mode, erase fail, program fail, cp, otp lock, factory.
// - erase fail flag reads 1 after failed erase, 0 by default.
// - program fail flag reads 1 after failed program, read only, 0 default.
// - lock register write 2F needs no prior write enable.
// - lock register write sets otp lockdown; then otp updates are refused.
// - 2F frame ending mid-byte is rejected.
// - mode 0 is range protection, 1 per-block; command 68 sets it, or the stored bit loads it at power-up.
// - mode bit is one-time; never returns to 0 once set.
// - range and per-block protection never act together.
// - at power-up, mode 1 means all blocks locked.
// - per-block mode allows program/erase only on unlocked blocks.
// - range bits select area; frozen while status disable set and wp pin low.
// - per-block lock bits volatile, set at power-up, single lock sets, unlock clears.
// - per-block mode with wp pin low protects every block; the otp area follows otp lockdown only.
// - opcode 68 alone in a frame sets the mode bit.
// - single lock commands act only in mode 1, address 23:16 picks block.
// - single lock and unlock need prior write enable.
// - lock commands ending mid-byte are discarded.
// - 3Ch with three address bytes returns lock bit in first output byte; mode 1 only, mode 0 drives no output.
// - returned lock bit 1 means protected, 0 means writable.
// - gang lock 7Eh and unlock 98h, alone, need write enable, mode 1.
// - protected program/erase attempts set fail flags; 30h clears them.
`timescale 1ns/1ps
`default_nettype none
module fwp_top #(
  parameter logic FACTORY_LOCK = 1'b0 // factory strap, arbitrary default
) (
  input wire logic clk_in,          // 40 MHz system clock
  input wire logic resetn_in,       // async reset, active low (power-up)
  input wire logic cs_n_in,         // chip select, active low
  input wire logic sclk_in,         // serial clock
  input wire logic si_in,           // serial data in
  input wire logic wp_n_in,         // write protect pin, active low
  output logic so_out,              // serial data out
  output logic so_oe_out,           // serial out enable, high while driving
  input wire logic mode_nv_in,      // stored non-volatile mode bit at power-up
  input wire logic otp_nv_in,       // stored non-volatile otp lockdown at power-up
  input wire logic status_wd_in,    // status register write disable bit
  input wire logic [3:0] bp_wr_in,  // requested range protect bits
  input wire logic bp_wr_req_in,    // pulse: request range bits write
  input wire logic cont_prog_in,    // continuous program mode active
  input wire logic prog_req_in,     // pulse: program attempt on block
  input wire logic erase_req_in,    // pulse: erase attempt on block
  input wire logic otp_req_in,      // attempt targets otp area
  input wire logic [7:0] blk_in,    // block of attempt
  input wire logic range_hit_in,    // block falls in range-protected area
  input wire logic prog_fail_in,    // pulse: array program failure
  input wire logic erase_fail_in,   // pulse: array erase failure
  output logic allow_out,           // registered: last attempt was allowed
  output logic [7:0] lock_reg_out,  // lock/fail register
  output logic [3:0] bp_out,        // range protect bits
  output logic mode_nv_wr_out       // pulse: burn mode bit into storage
);
  localparam int AW = fwp_pkg::BLOCK_AW;

  logic sel, cs_rise, sclk_fall, byte_p, aligned;
  logic [7:0] rx;
  logic lock_rd;

  fwp_spi_shift u_shift (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .cs_n_in(cs_n_in),
    .sclk_in(sclk_in),
    .si_in(si_in),
    .sel_out(sel),
    .cs_rise_out(cs_rise),
    .sclk_fall_out(sclk_fall),
    .byte_out(byte_p),
    .aligned_out(aligned),
    .data_out(rx)
  );

  typedef enum logic [3:0] {
    S_OP   = 4'h1,
    S_ADDR = 4'h2,
    S_OUT  = 4'h4,
    S_DONE = 4'h8
  } fwp_state_t;

  typedef struct packed {
    fwp_state_t st;
    logic [7:0] op;
    logic [1:0] nbytes;
    logic [7:0] blk;
    logic wel;
    logic mode;
    logic otp;
    logic efail;
    logic pfail;
    logic [3:0] bp;
    logic [7:0] oshift;
    logic so;
    logic oe;
    logic allow;
    logic nv_wr;
    logic init;
    logic cp;
  } fwp_top_st_t;
  fwp_top_st_t q, d;

  // mutual exclusion of schemes decided in one place
  function automatic logic protected_blk(input logic mode, input logic wp_n,
                                         input logic lockbit, input logic range_hit);
    if (mode) begin
      protected_blk = ~wp_n | lockbit;
    end else begin
      protected_blk = range_hit;
    end
  endfunction

  logic [1:0] wp_s;
  logic gang_fill, gang_val, single_wr, single_val, cmd_ok;
  logic [AW-1:0] mem_addr;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wp_s <= 2'h3;
    end else begin
      wp_s <= {wp_s[0], wp_n_in};
    end
  end

  always_comb begin
    d = q;
    d.nv_wr = 1'b0;
    d.cp = cont_prog_in;
    gang_fill = 1'b0;
    gang_val = 1'b1;
    single_wr = 1'b0;
    single_val = 1'b1;
    mem_addr = (q.st == S_OP) ? blk_in : q.blk;
    // stored bits read once right after release; no port feeds a reset value
    if (q.init) begin
      d.init = 1'b0;
      d.mode = mode_nv_in;
      d.otp = otp_nv_in;
      gang_fill = 1'b1;
      gang_val = 1'b1;
    end
    if (bp_wr_req_in && !(status_wd_in && !wp_s[1]) && !q.mode) begin
      d.bp = bp_wr_in;
    end
    if (sclk_fall && q.oe) begin
      d.so = q.oshift[7];
      d.oshift = {q.oshift[6:0], 1'b0};
    end
    case (q.st)
      S_OP: begin
        if (byte_p && sel) begin
          d.op = rx;
          d.nbytes = 2'h0;
          if (rx == fwp_pkg::OP_SINGLE_LOCK || rx == fwp_pkg::OP_SINGLE_UNLOCK ||
              rx == fwp_pkg::OP_READ_LOCK) begin
            d.st = S_ADDR;
          end else if (rx == fwp_pkg::OP_READ_LOCK_REG) begin
            d.oshift = {q.mode, q.efail, q.pfail, q.cp, 2'h0, q.otp, FACTORY_LOCK};
            d.oe = 1'b1;
            d.st = S_OUT;
          end else begin
            d.st = S_DONE;
          end
        end
      end
      S_ADDR: begin
        if (byte_p) begin
          if (q.nbytes == 2'h0) begin
            d.blk = rx;
          end
          d.nbytes = q.nbytes + 2'h1;
          if (q.nbytes == 2'(fwp_pkg::ADDR_BYTES - 1)) begin
            if (q.op == fwp_pkg::OP_READ_LOCK) begin
              if (q.mode) begin
                d.oshift = {7'h00, protected_blk(q.mode, wp_s[1], lock_rd, 1'b0)};
                d.oe = 1'b1;
                d.st = S_OUT;
              end else begin
                d.st = S_DONE;
              end
            end else begin
              d.st = S_DONE;
            end
          end
        end
      end
      S_OUT: begin
        d.st = S_OUT;
      end
      S_DONE: begin
        if (byte_p) begin
          d.op = 8'h00; // extra byte: command no longer alone in its frame
        end
      end
      default: begin
        d.st = S_OP;
      end
    endcase
    if (cs_rise) begin
      d.st = S_OP;
      d.oe = 1'b0;
      d.so = 1'b0;
      if (q.st == S_DONE && aligned) begin
        case (q.op)
          fwp_pkg::OP_WRITE_ENABLE: d.wel = 1'b1;
          fwp_pkg::OP_WRITE_LOCK_REG: begin
            d.otp = 1'b1;
          end
          fwp_pkg::OP_MODE_SELECT: begin
            if (!q.mode) begin
              d.nv_wr = 1'b1;
            end
            d.mode = 1'b1;
          end
          fwp_pkg::OP_SINGLE_LOCK, fwp_pkg::OP_SINGLE_UNLOCK: begin
            if (q.wel && q.mode) begin
              single_wr = 1'b1;
              single_val = (q.op == fwp_pkg::OP_SINGLE_LOCK);
            end
            d.wel = 1'b0;
          end
          fwp_pkg::OP_GANG_LOCK, fwp_pkg::OP_GANG_UNLOCK: begin
            if (q.wel && q.mode) begin
              gang_fill = 1'b1;
              gang_val = (q.op == fwp_pkg::OP_GANG_LOCK);
            end
            d.wel = 1'b0;
          end
          fwp_pkg::OP_CLEAR_FAIL: begin
            d.pfail = prog_fail_in;
            d.efail = erase_fail_in;
          end
          default: begin
            d.wel = q.wel;
          end
        endcase
      end
    end
    // attempts from the array engine; refused ones win over a clear in the same cycle
    if (prog_req_in || erase_req_in) begin
      d.allow = ~(otp_req_in ? q.otp : protected_blk(q.mode, wp_s[1], lock_rd, range_hit_in));
      if (!d.allow && prog_req_in) begin
        d.pfail = 1'b1;
      end
      if (!d.allow && erase_req_in) begin
        d.efail = 1'b1;
      end
    end
    // array failures win over a clear in the same cycle
    if (prog_fail_in) begin
      d.pfail = 1'b1;
    end
    if (erase_fail_in) begin
      d.efail = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '{st: S_OP, init: 1'b1, allow: 1'b0, bp: '0, default: '0};
    end else begin
      q <= d;
    end
  end

  fwp_lock_mem #(
    .DEPTH(fwp_pkg::BLOCK_COUNT),
    .AW(AW)
  ) u_mem (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .fill_in(gang_fill),
    .fill_val_in(gang_val),
    .wr_in(single_wr),
    .addr_in(mem_addr),
    .wr_val_in(single_val),
    .rd_out(lock_rd)
  );

  assign so_out = q.so;
  assign so_oe_out = q.oe;
  assign allow_out = q.allow;
  assign lock_reg_out = {q.mode, q.efail, q.pfail, q.cp, 2'h0, q.otp, 1'b0} |
                        {fwp_pkg::LOCK_REG_RESET[7:1], FACTORY_LOCK};
  assign bp_out = q.bp;
  assign mode_nv_wr_out = q.nv_wr;
  assign cmd_ok = cs_rise && (q.st == S_DONE) && aligned;

  AST_MODE_STICKY: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !q.init && $past(q.mode) |-> q.mode) else $error("mode bit fell back");
  AST_FAIL_SET: assert property (@(posedge clk_in) disable iff (!resetn_in)
    prog_fail_in |=> q.pfail) else $error("program fail not set");
  AST_ERASE_SET: assert property (@(posedge clk_in) disable iff (!resetn_in)
    erase_fail_in |=> q.efail) else $error("erase fail not set");
  AST_WP_LOW: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (prog_req_in && q.mode && !wp_s[1] && !otp_req_in) |=> !q.allow) else $error("wp low allowed write");
  AST_RANGE_ONLY: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (erase_req_in && !q.mode && !range_hit_in && !otp_req_in) |=> q.allow) else $error("range mode blocked");
  AST_OTP_LOCK: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (prog_req_in && otp_req_in && q.otp) |=> (!q.allow && q.pfail)) else $error("otp update allowed");
  AST_BP_FROZEN: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (status_wd_in && !wp_s[1]) |=> $stable(q.bp)) else $error("range bits changed");
  AST_MIDBYTE: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (cs_rise && !aligned && !q.init) |=> ($stable(q.mode) && $stable(q.otp))) else $error("mid-byte executed");

  // command, lock and output checks
  AST_WRITE_ENABLE_CMD_LATCH: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (cmd_ok && q.op == fwp_pkg::OP_WRITE_ENABLE) |=> q.wel) else $error("write enable not latched");
  AST_OTP_SET: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (cmd_ok && q.op == fwp_pkg::OP_WRITE_LOCK_REG) |=> q.otp) else $error("otp lockdown not set");
  AST_MODE_BURN: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (cmd_ok && q.op == fwp_pkg::OP_MODE_SELECT && !q.mode) |=> (q.mode && q.nv_wr)) else $error("mode not set");
  AST_SINGLE_GATED: assert property (@(posedge clk_in) disable iff (!resetn_in)
    single_wr |-> (q.mode && q.wel)) else $error("single lock without enable");
  AST_GANG_GATED: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (gang_fill && !q.init) |-> (q.mode && q.wel)) else $error("gang lock without enable");
  AST_INIT_LOCKED: assert property (@(posedge clk_in) disable iff (!resetn_in)
    q.init |-> (gang_fill && gang_val)) else $error("blocks not locked at power-up");
  AST_CLEAR_FLAGS: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (cmd_ok && q.op == fwp_pkg::OP_CLEAR_FAIL && !prog_fail_in && !erase_fail_in &&
     !prog_req_in && !erase_req_in) |=> (!q.pfail && !q.efail)) else $error("fail flags not cleared");
  AST_MODE_RANGE_BITS: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (bp_wr_req_in && q.mode) |=> $stable(q.bp)) else $error("range bits written in block mode");
  AST_LOCKED_BLOCK: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (prog_req_in && q.mode && lock_rd && !otp_req_in) |=> !q.allow) else $error("locked block allowed");
  AST_UNLOCKED_BLOCK: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (erase_req_in && q.mode && wp_s[1] && !lock_rd && !otp_req_in) |=> q.allow) else $error("unlocked refused");
  AST_ALLOW_HOLD: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !(prog_req_in || erase_req_in) |=> $stable(q.allow)) else $error("verdict changed without attempt");
  AST_FRAME_END_QUIET: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cs_rise |=> (!q.oe && !q.so)) else $error("output still driven after frame");
  AST_READ_MODE0: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (q.st == S_ADDR && byte_p && q.op == fwp_pkg::OP_READ_LOCK && !q.mode) |=> !q.oe)
    else $error("lock read answered in range mode");
  AST_PROG_REFUSED: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (prog_req_in && !otp_req_in && !q.mode && range_hit_in) |=> (!q.allow && q.pfail))
    else $error("range write allowed");
endmodule
`default_nettype wire

// ---- fwp_host_model.sv ----
// fwp_host_model: behavioural spi host that frames commands for the write-protect block.
// assumes: the bench calls frame one at a time; serial clock idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module fwp_host_model (
  output logic cs_n_out, // chip select, active low
  output logic sclk_out, // serial clock
  output logic si_out,   // serial data to device
  input wire logic so_in // serial data from device
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out = 1'b0;
  end
  // long low phase leaves the synced output path time to settle before sampling
  task automatic frame(input logic [31:0] tx, input int nbits, input int nrd, output logic [7:0] rx);
    rx = 8'h00;
    cs_n_out = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      si_out = tx[i];
      #120 sclk_out = 1'b1;
      #80 sclk_out = 1'b0;
    end
    for (int i = 0; i < nrd; i++) begin
      si_out = ~si_out;
      #120 sclk_out = 1'b1;
      rx = {rx[6:0], so_in};
      #80 sclk_out = 1'b0;
    end
    #100 cs_n_out = 1'b1;
    si_out = ~si_out;
    #300;
  endtask
endmodule
`default_nettype wire

// ---- test_flash_write_protect_and_lock_status.sv ----
// test_flash_write_protect_and_lock_status: self-checking bench with a reference model of the lock state.
// assumes: fwp_host_model drives the serial pins; all other inputs driven here on falling clk edges.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module test_flash_write_protect_and_lock_status;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic wp_n_in = 1'b1, mode_nv_in = 1'b0, otp_nv_in = 1'b0, status_wd_in = 1'b0;
  logic bp_wr_req_in = 1'b0, cont_prog_in = 1'b1, prog_req_in = 1'b0, erase_req_in = 1'b0;
  logic otp_req_in = 1'b0, range_hit_in = 1'b0, prog_fail_in = 1'b0, erase_fail_in = 1'b0;
  logic [3:0] bp_wr_in = 4'h0;
  logic [7:0] blk_in = 8'h00;
  logic so_out, so_oe_out, allow_out, mode_nv_wr_out;
  logic [7:0] lock_reg_out;
  logic [3:0] bp_out;
  wire cs_n, sclk, si;
  int seed = 79638;
  int n_mismatch = 0, checked = 0, nwr = 0, noe = 0;
  bit mode, otp, pf, ef, wel;
  bit lk [256];
  logic [3:0] bp_exp = 4'h0;
  logic [7:0] b, b0;

  always #12.5 clk_in = ~clk_in;

  fwp_top uut (.clk_in(clk_in), .resetn_in(resetn_in), .cs_n_in(cs_n), .sclk_in(sclk), .si_in(si),
    .wp_n_in(wp_n_in), .so_out(so_out), .so_oe_out(so_oe_out), .mode_nv_in(mode_nv_in),
    .otp_nv_in(otp_nv_in), .status_wd_in(status_wd_in), .bp_wr_in(bp_wr_in), .bp_wr_req_in(bp_wr_req_in),
    .cont_prog_in(cont_prog_in), .prog_req_in(prog_req_in), .erase_req_in(erase_req_in),
    .otp_req_in(otp_req_in), .blk_in(blk_in), .range_hit_in(range_hit_in), .prog_fail_in(prog_fail_in),
    .erase_fail_in(erase_fail_in), .allow_out(allow_out), .lock_reg_out(lock_reg_out), .bp_out(bp_out),
    .mode_nv_wr_out(mode_nv_wr_out));

  fwp_host_model host (.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si), .so_in(so_out));

  always @(posedge clk_in) begin
    if (mode_nv_wr_out === 1'b1) nwr++;
    if (so_oe_out === 1'b1) noe++;
  end

  function automatic logic [7:0] exp_reg();
    return {mode, ef, pf, cont_prog_in, 2'b00, otp, 1'b0};
  endfunction

  task automatic tally_and_finish;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // frames that end mid-byte leave the model untouched
  task automatic cmd(input logic [31:0] tx, input int nbits);
    logic [7:0] rx;
    logic [7:0] op;
    op = (nbits == 32) ? tx[31:24] : tx[7:0];
    host.frame(tx, nbits, 0, rx);
    if (nbits % 8 == 0) begin
      case (op)
        8'h06: wel = 1'b1;
        8'h2F: otp = 1'b1;
        8'h68: mode = 1'b1;
        8'h30: begin
          pf = 1'b0;
          ef = 1'b0;
        end
        8'h36, 8'h39: begin
          if (wel && mode) lk[tx[23:16]] = (op == 8'h36);
          wel = 1'b0;
        end
        8'h7E, 8'h98: begin
          if (wel && mode) foreach (lk[i]) lk[i] = (op == 8'h7E);
          wel = 1'b0;
        end
        default: ;
      endcase
    end
    `CHK(lock_reg_out, exp_reg())
  endtask

  task automatic rdlock(input logic [7:0] bk);
    logic [7:0] rx;
    int n0;
    n0 = noe;
    host.frame({8'h3C, bk, 16'($random(seed))}, 32, 8, rx);
    if (mode) begin
      `CHK(rx, {7'h00, lk[bk]})
    end else begin
      `CHK(noe, n0)
    end
  endtask

  task automatic attempt(input bit pe, input bit o, input logic [7:0] bk, input bit r);
    bit ok;
    ok = o ? !otp : (mode ? (wp_n_in === 1'b1 && !lk[bk]) : !r);
    // lock bit read is registered, so the block index leads the request by a cycle
    @(negedge clk_in);
    otp_req_in = o;
    blk_in = bk;
    range_hit_in = r;
    @(negedge clk_in);
    prog_req_in = pe;
    erase_req_in = !pe;
    @(negedge clk_in);
    prog_req_in = 1'b0;
    erase_req_in = 1'b0;
    if (!ok && pe) pf = 1'b1;
    if (!ok && !pe) ef = 1'b1;
    repeat (2) @(negedge clk_in);
    `CHK(allow_out, ok)
    `CHK(lock_reg_out, exp_reg())
  endtask

  task automatic bpw(input bit wd, input bit wpn, input logic [3:0] v);
    @(negedge clk_in);
    status_wd_in = wd;
    wp_n_in = wpn;
    // pin crosses two sync stages before the freeze sees it
    repeat (2) @(negedge clk_in);
    bp_wr_in = v;
    bp_wr_req_in = 1'b1;
    @(negedge clk_in);
    bp_wr_req_in = 1'b0;
    if (!(wd && !wpn)) bp_exp = v;
    @(negedge clk_in);
    `CHK(bp_out, bp_exp)
  endtask

  initial begin
    #2_000_000;
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    foreach (lk[i]) lk[i] = 1'b1;
    repeat (4) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    `CHK(lock_reg_out, exp_reg())
    bpw(1'b1, 1'b0, 4'h5);
    bpw(1'b0, 1'b0, 4'hA);
    bpw(1'b1, 1'b1, 4'h3);
    for (int k = 0; k < 4; k++) begin
      b = 8'($random(seed));
      attempt(k[0], 1'b0, b, k[1]);
    end
    b0 = 8'($random(seed));
    cmd(32'h06, 8);
    cmd({8'h39, b0, 16'h0000}, 32);
    rdlock(b0);
    attempt(1'b1, 1'b1, b0, 1'b0);
    cmd(32'h2F0, 12);
    cmd(32'h2F, 8);
    attempt(1'b1, 1'b1, b0, 1'b0);
    attempt(1'b0, 1'b1, b0, 1'b0);
    cmd(32'h30, 8);
    @(negedge clk_in);
    prog_fail_in = 1'b1;
    erase_fail_in = 1'b1;
    @(negedge clk_in);
    prog_fail_in = 1'b0;
    erase_fail_in = 1'b0;
    pf = 1'b1;
    ef = 1'b1;
    repeat (2) @(negedge clk_in);
    `CHK(lock_reg_out, exp_reg())
    host.frame(32'h2B, 8, 8, b);
    `CHK(b, exp_reg())
    cmd(32'h30, 8);
    wp_n_in = 1'b1;
    cmd(32'h68, 8);
    `CHK(nwr, 1)
    rdlock(b0);
    for (int k = 0; k < 3; k++) begin
      b = 8'($random(seed));
      rdlock(b);
      cmd({8'h39, b, 16'h0000}, 32);
      rdlock(b);
      cmd(32'h06, 8);
      cmd({8'h39, b, 16'h0000}, 32);
      rdlock(b);
      attempt(k[0], 1'b0, b, 1'b1);
      wp_n_in = 1'b0;
      attempt(k[0], 1'b0, b, 1'b0);
      wp_n_in = 1'b1;
      cmd(32'h06, 8);
      cmd({4'h0, 8'h36, b, 12'h000}, 28);
      rdlock(b);
      cmd(32'h06, 8);
      cmd({8'h36, b, 16'h0000}, 32);
      rdlock(b);
      attempt(k[0], 1'b0, b, 1'b0);
    end
    cmd(32'h06, 8);
    cmd(32'h98, 8);
    rdlock(b);
    cmd(32'h06, 8);
    cmd(32'h7E, 8);
    rdlock(b0);
    cmd(32'h06, 8);
    cmd(32'h98, 8);
    @(negedge clk_in);
    resetn_in = 1'b0;
    mode_nv_in = 1'b1;
    otp_nv_in = 1'b1;
    cont_prog_in = 1'b0;
    wel = 1'b0;
    pf = 1'b0;
    ef = 1'b0;
    foreach (lk[i]) lk[i] = 1'b1;
    repeat (4) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    `CHK(lock_reg_out, exp_reg())
    rdlock(b);
    cmd(32'h2F, 8);
    host.frame(32'h2B, 8, 8, b);
    `CHK(b, exp_reg())
    tally_and_finish;
  end
endmodule
`default_nettype wire
